//--- rtl/ncopr_pkg.sv
/*
 package for the nco phase programming registers: register offsets,
 field positions, reset values, update modes, bus carrier and decoders.
 assumes byte-wide registers reached at their byte offsets.
*/
`default_nettype none

package ncopr_pkg;

   // ------------------------------------------------------------------
   // sizes
   // ------------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int STEP_W = 48;
   localparam int IDX_W = 4;
   localparam int NUM_CH = 16;
   localparam int STEP_BYTES = 6;
   localparam int LANE_W = 3;

   // ------------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------------
   localparam logic [11:0] MAP_SEL_ADDR = 12'h374;
   localparam logic [11:0] UPD_CTRL_ADDR = 12'h375;
   localparam logic [11:0] STEP_BYTE0_ADDR = 12'h376;
   localparam logic [11:0] STEP_BYTE1_ADDR = 12'h377;
   localparam logic [11:0] STEP_BYTE2_ADDR = 12'h378;
   localparam logic [11:0] STEP_BYTE3_ADDR = 12'h379;
   localparam logic [11:0] STEP_BYTE4_ADDR = 12'h37a;
   localparam logic [11:0] STEP_BYTE5_ADDR = 12'h37b;
   localparam logic [11:0] SHIFT_BYTE0_ADDR = 12'h37d;

   // ------------------------------------------------------------------
   // fields and reset values
   // ------------------------------------------------------------------
   localparam int SEL_LSB = 0;
   localparam int SEL_MSB = 3;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [3:0] SEL_RESET = 4'h0;
   localparam logic [2:0] SHIFT_LANE = 3'h6;

   typedef enum logic {
      NCOPR_CONTINUOUS = 1'b0,
      NCOPR_ON_TRANSFER = 1'b1
   } ncopr_upd_mode_t;

   typedef struct packed {
      logic [11:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } ncopr_bus_req_t;

   // ------------------------------------------------------------------
   // decoders
   // ------------------------------------------------------------------
   function automatic logic ncopr_is_step(input logic [11:0] a);
      return (a >= STEP_BYTE0_ADDR) && (a <= STEP_BYTE5_ADDR);
   endfunction

   function automatic logic [2:0] ncopr_step_lane(input logic [11:0] a);
      logic [11:0] d;
      d = a - STEP_BYTE0_ADDR;
      return d[2:0];
   endfunction

endpackage

`default_nettype wire

//--- rtl/ncopr_stage_bank.sv
/*
 staged per-channel settings: a 48-bit phase step and the low offset
 byte for each register-map channel, with two read ports.
 assumes one byte written per cycle, lane 6 being the offset byte.
*/
`default_nettype none

module ncopr_stage_bank #(
   parameter int NCH = ncopr_pkg::NUM_CH,
   parameter int SW = ncopr_pkg::STEP_W
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // write port
   input wire logic wr_en,
   input wire logic [ncopr_pkg::IDX_W-1:0] wr_chan,
   input wire logic [2:0] wr_lane,
   input wire logic [7:0] wr_data,
   // software read port
   input wire logic [ncopr_pkg::IDX_W-1:0] rd_chan,
   output logic [SW-1:0] rd_step,
   output logic [7:0] rd_shift,
   // commit read port
   input wire logic [ncopr_pkg::IDX_W-1:0] up_chan,
   output logic [SW-1:0] up_step,
   output logic [7:0] up_shift
);
   import ncopr_pkg::*;

   logic [SW-1:0] step [NCH];
   logic [7:0] shift [NCH];

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         for (int c = 0; c < NCH; c++) begin
            step[c] <= '0;
            shift[c] <= REG_RESET;
         end
      end else if (wr_en) begin
         if (wr_lane == SHIFT_LANE) begin
            shift[wr_chan] <= wr_data;
         end else begin
            step[wr_chan][8*wr_lane +: 8] <= wr_data;
         end
      end
   end

   assign rd_step = step[rd_chan];
   assign rd_shift = shift[rd_chan];
   assign up_step = step[up_chan];
   assign up_shift = shift[up_chan];

endmodule

`default_nettype wire

//--- rtl/ncopr_phase_accum.sv
/*
 applied nco settings and phase accumulators for every channel; all
 accumulators run every cycle so switching channels stays coherent.
 assumes commit requests come from logic on the same clock.
*/
`default_nettype none

module ncopr_phase_accum #(
   parameter int NCH = ncopr_pkg::NUM_CH,
   parameter int SW = ncopr_pkg::STEP_W
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // commit of staged settings
   input wire logic commit,
   input wire logic [ncopr_pkg::IDX_W-1:0] commit_chan,
   input wire logic [SW-1:0] commit_step,
   input wire logic [7:0] commit_shift,
   // offset bits held elsewhere
   input wire logic [SW-9:0] shift_high,
   // output channel
   input wire logic [ncopr_pkg::IDX_W-1:0] nco_sel,
   output logic [SW-1:0] phase_out,
   output logic [SW-1:0] act_step_sel,
   output logic [7:0] act_shift_sel
);
   import ncopr_pkg::*;

   logic [SW-1:0] act_step [NCH];
   logic [7:0] act_shift [NCH];
   logic [SW-1:0] acc [NCH];

   // applied settings, loaded only for the indexed channel
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         for (int c = 0; c < NCH; c++) begin
            act_step[c] <= '0;
            act_shift[c] <= REG_RESET;
         end
      end else if (commit) begin
         act_step[commit_chan] <= commit_step;
         act_shift[commit_chan] <= commit_shift;
      end
   end

   // sum truncated to the accumulator width wraps modulo 2**48
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         for (int c = 0; c < NCH; c++) begin
            acc[c] <= '0;
         end
      end else begin
         for (int c = 0; c < NCH; c++) begin
            acc[c] <= SW'(acc[c] + act_step[c]);
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         phase_out <= '0;
      end else begin
         phase_out <= SW'(acc[nco_sel] + {shift_high, act_shift[nco_sel]});
      end
   end

   assign act_step_sel = act_step[nco_sel];
   assign act_shift_sel = act_shift[nco_sel];

endmodule

`default_nettype wire

//--- rtl/ncopr_regs.sv
/*
 register bank of one nco in the third downconverter: map channel
 select, phase update index, frequency tuning word bytes and the low
 phase offset byte, plus the commit path to the running nco.
 assumes a plain byte register port on ref_clk, one strobe per cycle,
 read data returned in the following cycle only.
*/
// Behaviour
// (R01) update index picks channel receiving new phase
// (R02) index codes 0 to 3 name channels 0-3
// (R03) continuous mode or commit on chip transfer
// (R04) 48-bit tuning word over six byte registers
// (R05) accumulator wraps modulo two to the 48th
// (R06) offset added to output phase, low byte
// (R07) index and phase bytes reset zero, read/write
// (R08) map select chooses which channel software accesses
// (R09) reserved control bits read zero, writes ignored
`default_nettype none

module ncopr_regs #(
   parameter int NCH = ncopr_pkg::NUM_CH,
   parameter int SW = ncopr_pkg::STEP_W
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // register port
   input wire ncopr_pkg::ncopr_bus_req_t req,
   output logic [7:0] rdata,
   // update control
   input wire ncopr_pkg::ncopr_upd_mode_t upd_mode,
   input wire logic chip_transfer,
   // offset bits above the low byte
   input wire logic [SW-9:0] shift_high,
   // nco output
   input wire logic [ncopr_pkg::IDX_W-1:0] nco_sel,
   output logic [SW-1:0] phase_out
);
   import ncopr_pkg::*;

   // ------------------------------------------------------------------
   // decode
   // ------------------------------------------------------------------
   logic [IDX_W-1:0] map_sel;
   logic [IDX_W-1:0] upd_idx;
   logic hit_map;
   logic hit_ctrl;
   logic hit_step;
   logic hit_shift;
   logic [2:0] lane;
   logic bank_wr;
   logic [2:0] bank_lane;
   logic commit;
   logic [SW-1:0] rd_step;
   logic [7:0] rd_shift;
   logic [SW-1:0] up_step;
   logic [7:0] up_shift;
   logic [SW-1:0] act_step_sel;
   logic [7:0] act_shift_sel;
   logic [7:0] next_rdata;

   assign hit_map = (req.addr == MAP_SEL_ADDR);
   assign hit_ctrl = (req.addr == UPD_CTRL_ADDR);
   assign hit_step = ncopr_is_step(req.addr);
   assign hit_shift = (req.addr == SHIFT_BYTE0_ADDR);
   assign lane = ncopr_step_lane(req.addr);

   // ------------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------------
   // upper nibble of either register is not stored
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         map_sel <= SEL_RESET; // see R07
      end else if (req.wr && hit_map) begin
         map_sel <= req.wdata[SEL_MSB:SEL_LSB]; // see R08
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         upd_idx <= SEL_RESET; // see R07
      end else if (req.wr && hit_ctrl) begin
         upd_idx <= req.wdata[SEL_MSB:SEL_LSB]; // see R01 see R09
      end
   end

   // ------------------------------------------------------------------
   // staged settings of the map-selected channel
   // ------------------------------------------------------------------
   assign bank_wr = req.wr && (hit_step || hit_shift); // see R08
   assign bank_lane = hit_step ? lane : SHIFT_LANE; // see R04

   ncopr_stage_bank #(
      .NCH(NCH),
      .SW(SW)
   ) u_stage (
      .ref_clk(ref_clk),
      .rst(rst),
      .wr_en(bank_wr),
      .wr_chan(map_sel),
      .wr_lane(bank_lane),
      .wr_data(req.wdata),
      .rd_chan(map_sel),
      .rd_step(rd_step),
      .rd_shift(rd_shift),
      .up_chan(upd_idx),
      .up_step(up_step),
      .up_shift(up_shift)
   );

   // ------------------------------------------------------------------
   // commit to the running nco
   // ------------------------------------------------------------------
   // index value is the channel number itself
   assign commit = (upd_mode == NCOPR_CONTINUOUS) || chip_transfer; // see R03

   ncopr_phase_accum #(
      .NCH(NCH),
      .SW(SW)
   ) u_accum (
      .ref_clk(ref_clk),
      .rst(rst),
      .commit(commit),
      .commit_chan(upd_idx), // see R02
      .commit_step(up_step),
      .commit_shift(up_shift),
      .shift_high(shift_high),
      .nco_sel(nco_sel),
      .phase_out(phase_out), // see R05 see R06
      .act_step_sel(act_step_sel),
      .act_shift_sel(act_shift_sel)
   );

   // ------------------------------------------------------------------
   // read path
   // ------------------------------------------------------------------
   always_comb begin
      next_rdata = REG_RESET;
      if (hit_map) begin
         next_rdata = {4'h0, map_sel};
      end else if (hit_ctrl) begin
         next_rdata = {4'h0, upd_idx}; // see R09
      end else if (hit_step) begin
         next_rdata = rd_step[8*lane +: 8]; // see R04
      end else if (hit_shift) begin
         next_rdata = rd_shift; // see R06
      end
   end

   // data stand only in the cycle after the read strobe
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdata <= REG_RESET;
      end else if (req.rd) begin
         rdata <= next_rdata;
      end else begin
         rdata <= REG_RESET;
      end
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   logic [1:0] post_rst;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         post_rst <= 2'h0;
      end else if (post_rst != 2'h3) begin
         post_rst <= post_rst + 2'h1;
      end
   end

   // output channel unchanged across the check cycle
   sequence s_sel_kept;
      nco_sel == $past(nco_sel);
   endsequence

   property p_idx_commit;
      @(posedge ref_clk) disable iff (rst)
      (commit && upd_idx == nco_sel) ##1 s_sel_kept |->
         (act_step_sel == $past(up_step)) &&
         (act_shift_sel == $past(up_shift));
   endproperty
   a_idx_commit: assert property (p_idx_commit) // see R01
      else $error("indexed channel did not take staged values");

   property p_idx_code;
      @(posedge ref_clk) disable iff (rst)
      (req.wr && hit_ctrl) |=> (upd_idx == $past(req.wdata[3:0]));
   endproperty
   a_idx_code: assert property (p_idx_code) // see R02
      else $error("update index does not hold written code");

   property p_mode_hold;
      @(posedge ref_clk) disable iff (rst)
      (upd_mode == NCOPR_ON_TRANSFER && !chip_transfer) ##1 s_sel_kept |->
         $stable(act_step_sel) && $stable(act_shift_sel);
   endproperty
   a_mode_hold: assert property (p_mode_hold) // see R03
      else $error("settings applied without chip transfer");

   property p_mode_cont;
      @(posedge ref_clk) disable iff (rst)
      (upd_mode == NCOPR_CONTINUOUS && upd_idx == nco_sel) ##1 s_sel_kept |->
         (act_step_sel == $past(up_step)) &&
         (act_shift_sel == $past(up_shift));
   endproperty
   a_mode_cont: assert property (p_mode_cont) // see R03
      else $error("continuous mode not committing");

   sequence s_step_write;
      req.wr && hit_step;
   endsequence

   sequence s_same_read;
      req.rd && !req.wr && (req.addr == $past(req.addr));
   endsequence

   property p_step_back;
      @(posedge ref_clk) disable iff (rst)
      s_step_write ##1 s_same_read |=> (rdata == $past(req.wdata, 2));
   endproperty
   a_step_back: assert property (p_step_back) // see R04
      else $error("tuning word byte did not read back");

   property p_wrap;
      @(posedge ref_clk) disable iff (rst || post_rst != 2'h3)
      ($past(nco_sel) == $past(nco_sel, 2) &&
         $past(act_shift_sel) == $past(act_shift_sel, 2) &&
         $past(shift_high) == $past(shift_high, 2)) |->
         (SW'(phase_out - $past(phase_out)) == $past(act_step_sel, 2));
   endproperty
   a_wrap: assert property (p_wrap) // see R05
      else $error("phase step differs from tuning word");

   property p_offset;
      @(posedge ref_clk) disable iff (rst || post_rst != 2'h3)
      ($past(nco_sel) == $past(nco_sel, 2)) |->
         (SW'(phase_out - $past(phase_out)) ==
          SW'($past(act_step_sel, 2) +
              {$past(shift_high), $past(act_shift_sel)} -
              {$past(shift_high, 2), $past(act_shift_sel, 2)}));
   endproperty
   a_offset: assert property (p_offset) // see R06
      else $error("phase offset not applied to output");

   property p_reset_zero;
      @(posedge ref_clk) disable iff (rst)
      $fell(rst) |->
         (map_sel == SEL_RESET) && (upd_idx == SEL_RESET) &&
         (rdata == REG_RESET) && (phase_out == '0);
   endproperty
   a_reset_zero: assert property (p_reset_zero) // see R07
      else $error("register not zero after reset");

   property p_map_read;
      @(posedge ref_clk) disable iff (rst)
      (req.rd && hit_step) |=> (rdata == $past(rd_step[8*lane +: 8]));
   endproperty
   a_map_read: assert property (p_map_read) // see R08
      else $error("read not from map-selected channel");

   property p_map_code;
      @(posedge ref_clk) disable iff (rst)
      (req.wr && hit_map) |=> (map_sel == $past(req.wdata[3:0]));
   endproperty
   a_map_code: assert property (p_map_code) // see R08
      else $error("map select does not hold written code");

   property p_reserved;
      @(posedge ref_clk) disable iff (rst)
      (req.rd && hit_ctrl) |=> (rdata[7:4] == 4'h0);
   endproperty
   a_reserved: assert property (p_reserved) // see R09
      else $error("reserved control bits read nonzero");

   property p_rdata_idle;
      @(posedge ref_clk) disable iff (rst)
      !req.rd |=> (rdata == 8'h00);
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) // see R07
      else $error("read data outside the answer cycle");

   property p_rst_clear;
      @(posedge ref_clk)
      rst |=> (phase_out == '0) && (rdata == 8'h00);
   endproperty
   a_rst_clear: assert property (p_rst_clear) // see R07
      else $error("outputs not cleared by reset");

   property p_idx_other;
      @(posedge ref_clk) disable iff (rst)
      (commit && upd_idx != nco_sel) ##1 s_sel_kept |->
         $stable(act_step_sel) && $stable(act_shift_sel);
   endproperty
   a_idx_other: assert property (p_idx_other) // see R01
      else $error("channel outside the index took new settings");

   property p_idx_hold;
      @(posedge ref_clk) disable iff (rst)
      !(req.wr && hit_ctrl) |=> $stable(upd_idx);
   endproperty
   a_idx_hold: assert property (p_idx_hold) // see R01
      else $error("update index moved without a write");

   property p_ctrl_read;
      @(posedge ref_clk) disable iff (rst)
      (req.rd && hit_ctrl) |=> (rdata == {4'h0, $past(upd_idx)});
   endproperty
   a_ctrl_read: assert property (p_ctrl_read) // see R07
      else $error("update index did not read back");

   property p_map_hold;
      @(posedge ref_clk) disable iff (rst)
      !(req.wr && hit_map) |=> $stable(map_sel);
   endproperty
   a_map_hold: assert property (p_map_hold) // see R08
      else $error("map select moved without a write");

   property p_map_val;
      @(posedge ref_clk) disable iff (rst)
      (req.rd && hit_map) |=> (rdata == {4'h0, $past(map_sel)});
   endproperty
   a_map_val: assert property (p_map_val) // see R08
      else $error("map select did not read back");

   property p_stage_byte;
      @(posedge ref_clk) disable iff (rst)
      s_step_write |=>
         (8'(rd_step >> (8 * $past(lane))) == $past(req.wdata));
   endproperty
   a_stage_byte: assert property (p_stage_byte) // see R04
      else $error("tuning word byte landed in the wrong lane");

   property p_shift_byte;
      @(posedge ref_clk) disable iff (rst)
      (req.wr && hit_shift) |=> (rd_shift == $past(req.wdata));
   endproperty
   a_shift_byte: assert property (p_shift_byte) // see R06
      else $error("offset byte not staged");

   property p_unmapped;
      @(posedge ref_clk) disable iff (rst)
      (req.rd && !(hit_map || hit_ctrl || hit_step || hit_shift)) |=>
         (rdata == 8'h00);
   endproperty
   a_unmapped: assert property (p_unmapped) // see R07
      else $error("unmapped address read nonzero");

endmodule

`default_nettype wire

//--- bench/ncopr_regs_test.sv
/*
 self-checking bench for the nco phase programming register bank.
 assumes the design's own assertions and a byte register port on ref_clk.
*/
`default_nettype none

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
   $display("[ERR] %s exp %0h got %0h", nm, e, g); end end

module ncopr_regs_test;
   timeunit 1ns;
   timeprecision 1ps;
   import ncopr_pkg::*;

   typedef struct packed {
      logic [11:0] a;
      logic [7:0] w;
      logic [7:0] e;
   } ncopr_row_t;

   logic ref_clk;
   logic rst;
   ncopr_bus_req_t req;
   logic [7:0] rdata;
   ncopr_upd_mode_t upd_mode;
   logic chip_transfer;
   logic [39:0] shift_high;
   logic [3:0] nco_sel;
   logic [47:0] phase_out;
   int errors = 0;
   int n_checks = 0;
   ncopr_row_t rows[11] = '{
      '{12'h374, 8'ha5, 8'h05}, '{12'h375, 8'hf3, 8'h03},
      '{12'h376, 8'h11, 8'h11}, '{12'h377, 8'h22, 8'h22},
      '{12'h378, 8'h33, 8'h33}, '{12'h379, 8'h44, 8'h44},
      '{12'h37a, 8'h55, 8'h55}, '{12'h37b, 8'h66, 8'h66},
      '{12'h37d, 8'h77, 8'h77}, '{12'h37c, 8'hff, 8'h00},
      '{12'h380, 8'hff, 8'h00}};

   ncopr_regs dut (
      .ref_clk(ref_clk),
      .rst(rst),
      .req(req),
      .rdata(rdata),
      .upd_mode(upd_mode),
      .chip_transfer(chip_transfer),
      .shift_high(shift_high),
      .nco_sel(nco_sel),
      .phase_out(phase_out)
   );

   // ------------------------------------------------------------------
   // clock and watchdog
   // ------------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   initial begin
      repeat (5000) @(posedge ref_clk);
      errors++;
      test_done();
   end

   // ------------------------------------------------------------------
   // bus and check tasks
   // ------------------------------------------------------------------
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      req.wr <= 1'b1;
      req.addr <= a;
      req.wdata <= d;
      @(posedge ref_clk);
      req.wr <= 1'b0;
   endtask

   task automatic rchk(input logic [11:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      req.rd <= 1'b1;
      req.addr <= a;
      @(posedge ref_clk);
      req.rd <= 1'b0;
      #1;
      `CHK("rdata", e, rdata)
   endtask

   // writes all six tuning word bytes of one map channel
   task automatic set_step(input logic [3:0] ch, input logic [47:0] v);
      wr(MAP_SEL_ADDR, {4'h0, ch});
      for (int k = 0; k < 6; k++) begin
         wr(STEP_BYTE0_ADDR + 12'(k), v[8*k +: 8]);
      end
   endtask

   // phase must advance by exactly the step per cycle, modulo 2^48
   task automatic step_chk(input logic [47:0] e);
      logic [47:0] p0;
      @(posedge ref_clk);
      #1;
      p0 = phase_out;
      @(posedge ref_clk);
      #1;
      `CHK("phase step", e, phase_out - p0)
   endtask

   task automatic commit();
      @(posedge ref_clk);
      chip_transfer <= 1'b1;
      @(posedge ref_clk);
      chip_transfer <= 1'b0;
      repeat (3) @(posedge ref_clk);
   endtask

   task automatic test_done();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial begin
      rst = 1'b1;
      req = '0;
      upd_mode = NCOPR_ON_TRANSFER;
      chip_transfer = 1'b0;
      shift_high = '0;
      nco_sel = 4'h0;
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      #1;
      `CHK("phase in reset", 48'h0, phase_out)
      foreach (rows[i]) rchk(rows[i].a, 8'h00);
      // table: write every row, then read every row back
      foreach (rows[i]) wr(rows[i].a, rows[i].w);
      foreach (rows[i]) rchk(rows[i].a, rows[i].e);
      // back to back write then read, data stands one cycle only
      @(posedge ref_clk);
      req.wr <= 1'b1;
      req.addr <= STEP_BYTE0_ADDR;
      req.wdata <= 8'h5a;
      @(posedge ref_clk);
      req.wr <= 1'b0;
      req.rd <= 1'b1;
      @(posedge ref_clk);
      req.rd <= 1'b0;
      #1;
      `CHK("rdata b2b", 8'h5a, rdata)
      @(posedge ref_clk);
      #1;
      `CHK("rdata idle", 8'h00, rdata)
      // staging is kept per map channel
      wr(MAP_SEL_ADDR, 8'h02);
      wr(STEP_BYTE0_ADDR, 8'h21);
      wr(MAP_SEL_ADDR, 8'h03);
      wr(STEP_BYTE0_ADDR, 8'h31);
      rchk(STEP_BYTE0_ADDR, 8'h31);
      wr(MAP_SEL_ADDR, 8'h02);
      rchk(STEP_BYTE0_ADDR, 8'h21);
      // each index code 0..3 commits only on transfer
      for (int c = 0; c < 4; c++) begin
         set_step(4'(c), 48'(c + 1));
         wr(UPD_CTRL_ADDR, 8'(c));
         nco_sel <= 4'(c);
         repeat (3) @(posedge ref_clk);
         step_chk(48'h0);
         commit();
         step_chk(48'(c + 1));
      end
      // index 3 is selected, so channel 0 settings must not move
      set_step(4'h0, 48'h9);
      nco_sel <= 4'h0;
      commit();
      step_chk(48'h1);
      // step of minus one wraps the accumulator every cycle
      set_step(4'h4, 48'hffff_ffff_ffff);
      wr(UPD_CTRL_ADDR, 8'h04);
      nco_sel <= 4'h4;
      commit();
      step_chk(48'hffff_ffff_ffff);
      // continuous mode applies without a transfer
      @(posedge ref_clk);
      upd_mode <= NCOPR_CONTINUOUS;
      set_step(4'h6, 48'h0000_0012_3400);
      wr(UPD_CTRL_ADDR, 8'h06);
      nco_sel <= 4'h6;
      repeat (3) @(posedge ref_clk);
      step_chk(48'h0000_0012_3400);
      // offset on a channel whose accumulator never moved
      wr(MAP_SEL_ADDR, 8'h07);
      wr(SHIFT_BYTE0_ADDR, 8'h3c);
      wr(UPD_CTRL_ADDR, 8'h07);
      nco_sel <= 4'h7;
      shift_high <= 40'h12;
      repeat (4) @(posedge ref_clk);
      #1;
      `CHK("phase offset", {40'h12, 8'h3c}, phase_out)
      // reset in mid-run clears staged and running state
      @(posedge ref_clk);
      rst <= 1'b1;
      shift_high <= '0;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      #1;
      `CHK("phase after reset", 48'h0, phase_out)
      rchk(MAP_SEL_ADDR, 8'h00);
      wr(MAP_SEL_ADDR, 8'h07);
      rchk(SHIFT_BYTE0_ADDR, 8'h00);
      rchk(UPD_CTRL_ADDR, 8'h00);
      test_done();
   end
endmodule

`default_nettype wire
